// file: pkg/thermal_monitor_pkg.sv
// Shared constants, register map and carrier types of the thermal monitor sequencer.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package thermal_monitor_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_REMOTE = 3;
  localparam int CH_W = 2;
  localparam int STRAP_W = 3;
  localparam int SLAVE_ADDR_W = 7;

  // Freeze window of the second temperature byte.
  localparam int CLK_FREQ_MHZ = 100;
  localparam int FREEZE_TIME_MS = 35;
  localparam int FREEZE_CYCLES = FREEZE_TIME_MS * 1000 * CLK_FREQ_MHZ;

  // Register byte offsets; per-channel registers step by one word.
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CH_ENABLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SLAVE_ADDR = 8'h0C;
  localparam logic [7:0] OFS_THRESH_BASE = 8'h10;
  localparam logic [7:0] OFS_TEMP_MSB_BASE = 8'h20;
  localparam logic [7:0] OFS_TEMP_LSB_BASE = 8'h30;
  localparam int REGION_LSB = 4;
  localparam int CH_SEL_LSB = 2;

  // Configuration register fields.
  localparam int CFG_W = 3;
  localparam int CFG_STANDBY_BIT = 0;
  localparam int CFG_INT_MODE_BIT = 1;
  localparam int CFG_OUT_EN_BIT = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h4;

  // Status register fields.
  localparam int STAT_EXCEED_LSB = 0;
  localparam int STAT_STANDBY_BIT = 4;
  localparam int STAT_ALERT_BIT = 5;
  localparam int STAT_BUSY_BIT = 6;
  localparam int STAT_CH_LSB = 8;

  localparam logic [NUM_CH-1:0] CH_ENABLE_RESET = 4'hF;
  localparam logic [15:0] THRESH_RESET = 16'h5500;
  localparam logic [SLAVE_ADDR_W-1:0] SLAVE_ADDR_BASE = 7'h18;

  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] lsb;
  } temp_word_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic start;
    logic [CH_W-1:0] channel;
  } conv_cmd_s;

  typedef struct packed {
    logic done;
    temp_word_s result;
  } conv_rsp_s;

endpackage : thermal_monitor_pkg

// file: rtl/channel_scheduler.sv
// Picks the next channel to convert, in order from a start pointer, skipping ineligible ones.
// Assumes fault flags come from the analog front end, one per remote channel.
`timescale 1ns/1ps
`default_nettype none
module channel_scheduler
  import thermal_monitor_pkg::*;
(
  input wire logic [CH_W-1:0] ptr,
  input wire logic [NUM_CH-1:0] ch_enable,
  input wire logic [NUM_REMOTE-1:0] diode_fault,
  output logic [NUM_CH-1:0] eligible,
  output logic pick_valid,
  output logic [CH_W-1:0] pick_ch
);
  import thermal_monitor_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_elig
      if (gi < NUM_REMOTE)
      begin : g_remote
        assign eligible[gi] = ch_enable[gi] & ~diode_fault[gi];
      end
      else
      begin : g_local
        assign eligible[gi] = ch_enable[gi];
      end
    end
  endgenerate

  // Scanning downward lets the nearest eligible channel at or after the pointer win.
  always_comb
  begin
    logic [CH_W-1:0] idx;
    idx = ptr;
    pick_valid = 1'b0;
    pick_ch = ptr;
    for (int k = NUM_CH - 1; k >= 0; k--)
    begin
      idx = ptr + CH_W'(k);
      if (eligible[idx])
      begin
        pick_valid = 1'b1;
        pick_ch = idx;
      end
    end
  end

endmodule : channel_scheduler
`default_nettype wire

// file: rtl/result_bank.sv
// Per-channel temperature result registers with a freezable low-byte view.
// Assumes msb_rd and lsb_rd are one-cycle pulses from the register bus.
`timescale 1ns/1ps
`default_nettype none
module result_bank
  import thermal_monitor_pkg::*;
#(
  parameter int unsigned FREEZE_CYCLES_P = FREEZE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [CH_W-1:0] wr_ch,
  input wire thermal_monitor_pkg::temp_word_s wr_data,
  input wire logic msb_rd,
  input wire logic lsb_rd,
  input wire logic [CH_W-1:0] rd_ch,
  output thermal_monitor_pkg::temp_word_s [NUM_CH-1:0] live_q,
  output logic [NUM_CH-1:0][7:0] lsb_view_q,
  output logic [NUM_CH-1:0] frozen_q
);
  import thermal_monitor_pkg::*;

  logic [31:0] timer_ff;
  logic timeout;

  assign timeout = (|frozen_q) && (timer_ff == 32'(FREEZE_CYCLES_P - 1));

  // The timer restarts on every high-byte read and runs only while a byte is held.
  always_ff @(posedge clk)
  begin
    if (reset || msb_rd || !(|frozen_q) || timeout)
      timer_ff <= '0;
    else
      timer_ff <= timer_ff + 32'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      wire wr_hit = wr_en && (wr_ch == CH_W'(gi));
      wire msb_hit = msb_rd && (rd_ch == CH_W'(gi));
      wire lsb_hit = lsb_rd && (rd_ch == CH_W'(gi));
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          live_q[gi] <= '0;
          lsb_view_q[gi] <= 8'h00;
          frozen_q[gi] <= 1'b0;
        end
        else
        begin
          if (wr_hit)
            live_q[gi] <= wr_data;
          if (!frozen_q[gi])
            lsb_view_q[gi] <= wr_hit ? wr_data.lsb : live_q[gi].lsb;
          frozen_q[gi] <= msb_hit || (frozen_q[gi] && !lsb_hit && !timeout);
        end
      end

      a_lsb_held: assert property (@(posedge clk) disable iff (reset)
        frozen_q[gi] |=> $stable(lsb_view_q[gi]))
        else $error("Held low byte changed while frozen.");
    end
  endgenerate

  a_result_written: assert property (@(posedge clk) disable iff (reset)
    wr_en |=> live_q[$past(wr_ch)] == $past(wr_data))
    else $error("Conversion result not stored in its channel.");

endmodule : result_bank
`default_nettype wire

// file: rtl/thermal_monitor_sequencer.sv
// Conversion sequencer, threshold output and APB register file of the thermal monitor.
// Assumes an analog front end that answers each start with one done pulse and result.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module thermal_monitor_sequencer
  import thermal_monitor_pkg::*;
#(
  parameter int unsigned FREEZE_CYCLES_P = FREEZE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire thermal_monitor_pkg::apb_req_s apb_req,
  output thermal_monitor_pkg::apb_rsp_s apb_rsp,
  output thermal_monitor_pkg::conv_cmd_s conv_cmd,
  input wire thermal_monitor_pkg::conv_rsp_s conv_rsp,
  input wire logic [NUM_REMOTE-1:0] diode_fault,
  input wire logic [STRAP_W-1:0] address_select_input,
  output logic [SLAVE_ADDR_W-1:0] slave_address,
  output logic over_temp_output_o,
  output logic over_temp_output_oe
);
  import thermal_monitor_pkg::*;

  typedef enum {ST_SELECT, ST_CONVERT, ST_STANDBY} seq_state_e;

  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [CFG_W-1:0] cfg_ff;
  logic [NUM_CH-1:0] ch_enable_ff;
  logic [NUM_CH-1:0][15:0] thresh_ff;
  logic [CH_W-1:0] ptr_ff;
  logic [CH_W-1:0] nxt_ptr;
  logic [CH_W-1:0] ch_ff;
  logic start_ff;
  logic alert_ff;
  logic [NUM_CH-1:0] exceed_prev_ff;
  logic strap_taken_ff;
  logic [SLAVE_ADDR_W-1:0] slave_addr_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;

  logic [NUM_CH-1:0] eligible;
  logic pick_valid;
  logic [CH_W-1:0] pick_ch;
  temp_word_s [NUM_CH-1:0] live_q;
  logic [NUM_CH-1:0][7:0] lsb_view_q;
  logic [NUM_CH-1:0] frozen_q;
  logic [NUM_CH-1:0] exceed;

  // Bus decode.
  wire setup = apb_req.psel && !apb_req.penable;
  wire access = apb_req.psel && apb_req.penable;
  wire wr_access = access && apb_req.pwrite;
  wire rd_access = access && !apb_req.pwrite;
  wire [3:0] region = apb_req.paddr[7:REGION_LSB];
  wire [CH_W-1:0] reg_ch = apb_req.paddr[CH_SEL_LSB+CH_W-1:CH_SEL_LSB];
  wire aligned = (apb_req.paddr[CH_SEL_LSB-1:0] == 2'h0);
  wire hit_config = (apb_req.paddr == OFS_CONFIG);
  wire hit_enable = (apb_req.paddr == OFS_CH_ENABLE);
  wire hit_status = (apb_req.paddr == OFS_STATUS);
  wire hit_addr = (apb_req.paddr == OFS_SLAVE_ADDR);
  wire hit_thresh = aligned && (region == OFS_THRESH_BASE[7:REGION_LSB]);
  wire hit_msb = aligned && (region == OFS_TEMP_MSB_BASE[7:REGION_LSB]);
  wire hit_lsb = aligned && (region == OFS_TEMP_LSB_BASE[7:REGION_LSB]);
  wire mapped = hit_config || hit_enable || hit_status || hit_addr || hit_thresh
    || hit_msb || hit_lsb;
  wire status_rd = rd_access && hit_status;
  wire msb_rd = rd_access && hit_msb;
  wire lsb_rd = rd_access && hit_lsb;

  wire standby_req = cfg_ff[CFG_STANDBY_BIT];
  wire int_mode = cfg_ff[CFG_INT_MODE_BIT];
  wire out_en = cfg_ff[CFG_OUT_EN_BIT];
  wire conv_done = (state_ff == ST_CONVERT) && conv_rsp.done;

  wire [31:0] status_word = (32'(exceed) << STAT_EXCEED_LSB)
    | (32'(state_ff == ST_STANDBY) << STAT_STANDBY_BIT)
    | (32'(alert_ff) << STAT_ALERT_BIT)
    | (32'(state_ff == ST_CONVERT) << STAT_BUSY_BIT)
    | (32'(ch_ff) << STAT_CH_LSB);

  // Read data is prepared in the setup phase so it stands through the access phase.
  wire [31:0] rd_mux = hit_config ? 32'(cfg_ff)
    : hit_enable ? 32'(ch_enable_ff)
    : hit_status ? status_word
    : hit_addr ? 32'(slave_addr_ff)
    : hit_thresh ? 32'(thresh_ff[reg_ch])
    : hit_msb ? 32'(live_q[reg_ch].msb)
    : hit_lsb ? 32'(lsb_view_q[reg_ch])
    : 32'h0000_0000;

  assign apb_rsp.prdata = prdata_ff;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access && slverr_ff;

  channel_scheduler u_sched (
    .ptr(ptr_ff),
    .ch_enable(ch_enable_ff),
    .diode_fault(diode_fault),
    .eligible(eligible),
    .pick_valid(pick_valid),
    .pick_ch(pick_ch)
  );

  result_bank #(
    .FREEZE_CYCLES_P(FREEZE_CYCLES_P)
  ) u_bank (
    .clk(clk),
    .reset(reset),
    .wr_en(conv_done),
    .wr_ch(ch_ff),
    .wr_data(conv_rsp.result),
    .msb_rd(msb_rd),
    .lsb_rd(lsb_rd),
    .rd_ch(reg_ch),
    .live_q(live_q),
    .lsb_view_q(lsb_view_q),
    .frozen_q(frozen_q)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_cmp
      assign exceed[gi] = $signed(live_q[gi]) > $signed(thresh_ff[gi]);
    end
  endgenerate

  // Sequencer next state.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ptr = ptr_ff;
    case (state_ff)
      ST_SELECT:
      begin
        if (standby_req)
        begin
          nxt_state = ST_STANDBY;
          nxt_ptr = '0;
        end
        else if (pick_valid)
          nxt_state = ST_CONVERT;
      end
      ST_CONVERT:
      begin
        if (conv_rsp.done)
        begin
          nxt_ptr = ch_ff + CH_W'(1);
          if (standby_req)
          begin
            nxt_state = ST_STANDBY;
            nxt_ptr = '0;
          end
          else
            nxt_state = ST_SELECT;
        end
      end
      ST_STANDBY:
      begin
        nxt_ptr = '0;
        if (!standby_req)
          nxt_state = ST_SELECT;
      end
      default:
      begin
        nxt_state = ST_SELECT;
        nxt_ptr = '0;
      end
    endcase
  end

  wire launch = (state_ff == ST_SELECT) && !standby_req && pick_valid;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= ST_SELECT;
      ptr_ff <= '0;
      ch_ff <= '0;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ptr_ff <= nxt_ptr;
      start_ff <= launch;
      if (launch)
        ch_ff <= pick_ch;
    end
  end

  assign conv_cmd.start = start_ff;
  assign conv_cmd.channel = ch_ff;

  // Software-visible registers; the sequencer never writes them.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_ff <= CFG_RESET;
      ch_enable_ff <= CH_ENABLE_RESET;
      thresh_ff <= {NUM_CH{THRESH_RESET}};
    end
    else if (wr_access)
    begin
      if (hit_config)
        cfg_ff <= apb_req.pwdata[CFG_W-1:0];
      if (hit_enable)
        ch_enable_ff <= apb_req.pwdata[NUM_CH-1:0];
      if (hit_thresh)
        thresh_ff[reg_ch] <= apb_req.pwdata[15:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      prdata_ff <= rd_mux;
      slverr_ff <= !mapped;
    end
  end

  // A new exceedance sets the alert; it wins over a status read in the same cycle.
  wire new_exceed = |(exceed & ~exceed_prev_ff);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      exceed_prev_ff <= '0;
      alert_ff <= 1'b0;
    end
    else
    begin
      exceed_prev_ff <= exceed;
      alert_ff <= new_exceed || (alert_ff && !status_rd);
    end
  end

  wire over_temp_assert = out_en && (int_mode ? alert_ff : (|exceed));

  assign over_temp_output_o = 1'b0;
  assign over_temp_output_oe = over_temp_assert;

  // The strap is caught on the first edge after reset and then kept.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_taken_ff <= 1'b0;
      slave_addr_ff <= SLAVE_ADDR_BASE;
    end
    else if (!strap_taken_ff)
    begin
      strap_taken_ff <= 1'b1;
      slave_addr_ff <= SLAVE_ADDR_BASE + SLAVE_ADDR_W'(address_select_input);
    end
  end

  assign slave_address = slave_addr_ff;

  a_seq_ptr_advance: assert property (@(posedge clk) disable iff (reset)
    (conv_done && !standby_req) |=> (ptr_ff == $past(ch_ff) + CH_W'(1)))
    else $error("Sequence pointer did not advance past finished channel.");

  a_skip_fault: assert property (@(posedge clk) disable iff (reset)
    (conv_cmd.start && (conv_cmd.channel < CH_W'(NUM_REMOTE)))
      |-> !$past(diode_fault[pick_ch]))
    else $error("Conversion started on a faulty remote channel.");

  a_skip_disabled: assert property (@(posedge clk) disable iff (reset)
    conv_cmd.start |-> $past(ch_enable_ff[pick_ch]))
    else $error("Conversion started on a disabled channel.");

  a_out_compare: assert property (@(posedge clk) disable iff (reset)
    over_temp_output_oe == (out_en && (int_mode ? alert_ff : (|exceed))))
    else $error("Over-temperature output does not match its mode.");

  a_alert_latched: assert property (@(posedge clk) disable iff (reset)
    (alert_ff && !status_rd) |=> alert_ff)
    else $error("Alert dropped without a status read.");

  a_strap_hold: assert property (@(posedge clk) disable iff (reset)
    strap_taken_ff |=> $stable(slave_addr_ff))
    else $error("Slave address changed after power-up.");

  a_standby_idle: assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_STANDBY) |=> !conv_cmd.start)
    else $error("Conversion started during standby.");

  a_bus_live: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == ST_STANDBY) && wr_access && hit_thresh)
      |=> (thresh_ff[$past(reg_ch)] == $past(apb_req.pwdata[15:0])))
    else $error("Register write lost during standby.");

  a_finish_conv: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == ST_CONVERT) && standby_req && !conv_rsp.done) |=> (state_ff == ST_CONVERT))
    else $error("Conversion abandoned on standby request.");

  a_resume_first: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == ST_STANDBY) && !standby_req) |=> ((state_ff == ST_SELECT) && (ptr_ff == '0)))
    else $error("Sequence did not restart at remote channel one.");

endmodule : thermal_monitor_sequencer
`default_nettype wire

// file: verif/conv_frontend_model.sv
// Behavioural analog front end: answers each conversion start with one done pulse and result.
// Assumes start is a one-cycle pulse and the bench supplies the temperature of every channel.
`timescale 1ns/1ps
`default_nettype none
module conv_frontend_model
  import thermal_monitor_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire thermal_monitor_pkg::conv_cmd_s conv_cmd,
  input wire logic [7:0] latency,
  input wire thermal_monitor_pkg::temp_word_s [NUM_CH-1:0] temps,
  output var thermal_monitor_pkg::conv_rsp_s conv_rsp
);
  import thermal_monitor_pkg::*;

  logic busy_ff;
  logic [7:0] cnt_ff;
  logic [CH_W-1:0] ch_ff;

  // Outside the done pulse the result toggles every cycle, so a late capture shows up.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      ch_ff <= '0;
      conv_rsp <= '0;
    end
    else
    begin
      conv_rsp.done <= 1'b0;
      conv_rsp.result <= ~conv_rsp.result;
      if (conv_cmd.start)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= latency;
        ch_ff <= conv_cmd.channel;
      end
      else if (busy_ff && cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
      else if (busy_ff)
      begin
        busy_ff <= 1'b0;
        conv_rsp.done <= 1'b1;
        conv_rsp.result <= temps[ch_ff];
      end
    end
  end
endmodule : conv_frontend_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench of the thermal monitor sequencer, driven over APB.
// Assumes the package, the design files and the front end model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import thermal_monitor_pkg::*;
  localparam int FRZ = 20;
  localparam temp_word_s [NUM_CH-1:0] T0 = {16'h1A40, 16'h3000, 16'h2000, 16'h1900};
  logic clk = 1'b0;
  logic reset = 1'b1;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  conv_cmd_s conv_cmd;
  conv_rsp_s conv_rsp;
  logic [NUM_REMOTE-1:0] diode_fault = '0;
  logic [STRAP_W-1:0] address_select_input = 3'h5;
  logic [SLAVE_ADDR_W-1:0] slave_address;
  logic over_temp_output_o;
  logic over_temp_output_oe;
  logic [7:0] latency = 8'h04;
  temp_word_s [NUM_CH-1:0] temps = T0;
  logic [31:0] rd_q;
  logic err_q;
  logic [CH_W-1:0] seq_q[$];
  int fails = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  thermal_monitor_sequencer #(.FREEZE_CYCLES_P(FRZ)) thermal_monitor_sequencer_inst (
    .clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .conv_cmd(conv_cmd), .conv_rsp(conv_rsp), .diode_fault(diode_fault),
    .address_select_input(address_select_input), .slave_address(slave_address),
    .over_temp_output_o(over_temp_output_o), .over_temp_output_oe(over_temp_output_oe));

  conv_frontend_model conv_frontend_model_inst (
    .clk(clk), .reset(reset), .conv_cmd(conv_cmd), .latency(latency), .temps(temps),
    .conv_rsp(conv_rsp));

  always @(posedge clk)
    if (conv_cmd.start === 1'b1)
      seq_q.push_back(conv_cmd.channel);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1)
      @(posedge clk);
    rd_q = apb_rsp.prdata;
    err_q = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_q, exp);
  endtask : rd_chk

  task automatic wait_starts(input int n);
    while (seq_q.size() < n)
      @(posedge clk);
  endtask : wait_starts

  // Clearing between edges keeps a start logged at the same edge out of the new record.
  task automatic clear_seq;
    @(negedge clk);
    seq_q.delete();
  endtask : clear_seq

  task automatic oe_chk(input logic exp);
    repeat (2) @(posedge clk);
    check(32'(over_temp_output_oe), 32'(exp));
  endtask : oe_chk

  task automatic t_reset;
    repeat (2) @(posedge clk);
    address_select_input <= 3'h2;
    repeat (2) @(posedge clk);
    check(32'(slave_address), 32'(SLAVE_ADDR_BASE + 7'h05));
    rd_chk(OFS_SLAVE_ADDR, 32'(SLAVE_ADDR_BASE + 7'h05));
    rd_chk(OFS_CONFIG, 32'(CFG_RESET));
    rd_chk(OFS_CH_ENABLE, 32'(CH_ENABLE_RESET));
    rd_chk(OFS_THRESH_BASE + 8'h0C, 32'(THRESH_RESET));
    check(32'(over_temp_output_oe), 32'h0);
    rd_chk(8'h44, 32'h0);
    check(32'(err_q), 32'h1);
  endtask : t_reset

  task automatic t_order;
    clear_seq();
    wait_starts(9);
    for (int i = 1; i < 9; i++)
      check(32'(seq_q[i]), 32'(CH_W'(seq_q[i-1] + 2'h1)));
    for (int c = 0; c < NUM_CH; c++)
    begin
      rd_chk(OFS_TEMP_MSB_BASE + 8'(4*c), 32'(T0[c].msb));
      rd_chk(OFS_TEMP_LSB_BASE + 8'(4*c), 32'(T0[c].lsb));
    end
  endtask : t_order

  task automatic t_skip;
    diode_fault <= 3'b010;
    apb(1'b1, OFS_CH_ENABLE, 32'h7);
    clear_seq();
    wait_starts(5);
    for (int i = 2; i < 5; i++)
    begin
      check(32'(seq_q[i] ^ seq_q[i-1]), 32'h2);
      check(32'(seq_q[i][0]), 32'h0);
    end
    diode_fault <= 3'b000;
    apb(1'b1, OFS_CH_ENABLE, 32'hF);
  endtask : t_skip

  task automatic t_compare;
    apb(1'b1, OFS_THRESH_BASE + 8'h08, 32'h3000);
    oe_chk(1'b0);
    apb(1'b1, OFS_THRESH_BASE + 8'h08, 32'h2FFF);
    oe_chk(1'b1);
    check(32'(over_temp_output_o), 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h0);
    oe_chk(1'b0);
    apb(1'b1, OFS_CONFIG, 32'h4);
    oe_chk(1'b1);
    apb(1'b1, OFS_THRESH_BASE + 8'h08, 32'h5500);
    oe_chk(1'b0);
  endtask : t_compare

  task automatic t_interrupt;
    apb(1'b1, OFS_CONFIG, 32'h6);
    apb(1'b0, OFS_STATUS, 32'h0);
    oe_chk(1'b0);
    apb(1'b1, OFS_THRESH_BASE, 32'h1000);
    oe_chk(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(32'(rd_q[STAT_ALERT_BIT]), 32'h1);
    check(32'(rd_q[STAT_EXCEED_LSB]), 32'h1);
    oe_chk(1'b0);
    apb(1'b1, OFS_THRESH_BASE, 32'h5500);
    apb(1'b1, OFS_CONFIG, 32'h4);
  endtask : t_interrupt

  task automatic t_standby;
    logic [CH_W-1:0] ch;
    latency <= 8'h1E;
    clear_seq();
    wait_starts(1);
    ch = seq_q[0];
    temps[ch] <= 16'h2222;
    apb(1'b1, OFS_CONFIG, 32'h5);
    repeat (80) @(posedge clk);
    check(32'(seq_q.size()), 32'h1);
    rd_chk(OFS_TEMP_MSB_BASE + {4'h0, ch, 2'h0}, 32'h22);
    rd_chk(OFS_TEMP_LSB_BASE + {4'h0, ch, 2'h0}, 32'h22);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(32'(rd_q[STAT_STANDBY_BIT]), 32'h1);
    apb(1'b1, OFS_THRESH_BASE + 8'h04, 32'h4444);
    rd_chk(OFS_THRESH_BASE + 8'h04, 32'h4444);
    latency <= 8'h04;
    temps <= T0;
    apb(1'b1, OFS_CONFIG, 32'h4);
    wait_starts(2);
    check(32'(seq_q[1]), 32'h0);
    apb(1'b1, OFS_THRESH_BASE + 8'h04, 32'h5500);
    repeat (10) @(posedge clk);
  endtask : t_standby

  task automatic t_freeze;
    apb(1'b1, OFS_CH_ENABLE, 32'h1);
    rd_chk(OFS_TEMP_MSB_BASE, 32'h19);
    temps[0] <= 16'h1977;
    repeat (10) @(posedge clk);
    rd_chk(OFS_TEMP_LSB_BASE, 32'h00);
    rd_chk(OFS_TEMP_LSB_BASE, 32'h77);
    temps[0] <= 16'h19AA;
    apb(1'b0, OFS_TEMP_MSB_BASE, 32'h0);
    repeat (FRZ + 10) @(posedge clk);
    rd_chk(OFS_TEMP_LSB_BASE, 32'hAA);
    apb(1'b1, OFS_CH_ENABLE, 32'hF);
  endtask : t_freeze

  task automatic results;
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_order();
    t_skip();
    t_compare();
    t_interrupt();
    t_standby();
    t_freeze();
    results();
  end
endmodule : tb
`default_nettype wire
